// [bench/oss_chk_sva.sv]
`timescale 1ns/100ps
// Bus handshake and clock hand-over checks at the top ports
module oss_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_mode,
    input wire logic clock_input_pin_is_clock,
    input wire logic int_osc_running
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Answers stand until the master takes them
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
    // No new request is accepted while an answer is pending
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while busy");
    write_busy_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("wready busy");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write answer");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("no read answer");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 4'hC |-> ##[1:2] (s_axi_rvalid &&
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
        else $error("unmapped read");
    // Outside stop mode, internal source stops only once the input pin carries the clock
    osc_handover_a: assert property ($fell(int_osc_running) &&
        !stop_mode |-> clock_input_pin_is_clock) else $error("early stop");
endmodule
bind oss_top oss_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .stop_mode, .clock_input_pin_is_clock,
    .int_osc_running);

// [bench/oss_far_model.sv]
`timescale 1ns/100ps
// External clock on the input pin, and a bus clock consumer
module oss_far_model (
    input wire logic aclk,
    input wire logic run,
    input wire logic clr,
    input wire logic lvl,
    input wire logic bus_clock_times4,
    input wire logic bus_clock_times2,
    output logic clock_input_pin,
    output int n4,
    output int n2
);
    parameter int HALF = 7;
    logic p4 = 1'b0;
    logic p2 = 1'b0;
    int t = 0;
    initial clock_input_pin = 1'b0;
    // Edge counts; the source clock stands at lvl outside frames
    always @(posedge aclk) begin
        p4 <= bus_clock_times4;
        p2 <= bus_clock_times2;
        n4 <= clr ? 0 : n4 + int'(bus_clock_times4 && !p4);
        n2 <= clr ? 0 : n2 + int'(bus_clock_times2 && !p2);
        t <= (run && t < HALF - 1) ? t + 1 : 0;
        if (!run) begin
            clock_input_pin <= lvl;
        end else if (t == HALF - 1) begin
            clock_input_pin <= !clock_input_pin;
        end
    end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
// Register bus driver, read monitor and scenarios
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_mode = 1'b0;
    logic stop_osc_disable = 1'b0, wait_mode = 1'b0, monitor_bypass = 1'b0;
    logic run = 1'b0, clr = 1'b0, lvl = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, clock_input_pin, clock_output_pin_o;
    logic clock_output_pin_oe, clock_input_pin_is_clock, int_osc_running;
    logic bus_clock_times4, bus_clock_times2;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [33:0] rq[$];
    logic [33:0] exp_v;
    logic [7:0] tr;
    int n4, n2, fail_count = 0, total_checks = 0;
    int seed = 32'hA5DC0EA2;
    int c[3];

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    oss_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode,
        .stop_osc_disable, .wait_mode, .monitor_bypass, .clock_input_pin,
        .clock_output_pin_o, .clock_output_pin_oe, .clock_input_pin_is_clock,
        .bus_clock_times4, .bus_clock_times2, .int_osc_running);
    oss_far_model i_far (.aclk, .run, .clr, .lvl, .bus_clock_times4,
        .bus_clock_times2, .clock_input_pin, .n4, .n2);

    task automatic chk(input string nm, input logic [33:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    // Expected {resp, data} is noted before the request goes out
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic cnt(output int v);
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (1000) @(posedge aclk);
        v = n4;
        chk("x2", 34'(n4 >= 2 * n2 - 1 && n4 <= 2 * n2 + 1), 34'h1);
    endtask

    task automatic pin(input logic [7:0] ctl, input logic oe);
        wr(4'h0, ctl);
        repeat (8) @(posedge aclk);
        chk("oe", 34'(clock_output_pin_oe), 34'(oe));
    endtask

    // Bounded wait for the internal oscillator to reach a state
    task automatic wait_run(input logic v);
        for (int n = 0; n < 400 && int_osc_running !== v; n++) begin
            @(posedge aclk);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Takes the oldest note whenever a read answer is handed over
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            exp_v = rq.pop_front();
            chk("read", {s_axi_rresp, s_axi_rdata}, exp_v);
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            chk("bresp", 34'(s_axi_bresp), 34'(oss_pkg::RESP_OKAY));
        end
    end

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 34'h0);
        rd(4'h4, {26'h0, oss_pkg::TRIM_RESET});
        rd(4'hC, {oss_pkg::RESP_SLVERR, 32'h0});
        $display("test reset done");
        tr = 8'($random(seed));
        wr(4'h4, tr);
        rd(4'h4, {26'h0, tr});
        for (int i = 0; i < 9; i++) begin
            wr(4'h0, {2'h0, 2'(i / 3), 2'(i % 3), 2'h0});
            rd(4'h0, {28'h0, 2'(i / 3), 2'(i % 3), 2'h0});
        end
        // Reserved codes keep the old fields; the engaged flag is read-only
        wr(4'h0, 8'h3F);
        rd(4'h0, {26'h0, 8'h2A});
        wr(4'h0, 8'h00);
        $display("test fields done");
        for (int f = 0; f < 3; f++) begin
            wr(4'h0, {2'h0, 2'(f), 4'h0});
            cnt(c[f]);
        end
        chk("freq", 34'(c[1] > c[0] && c[2] > c[1]), 34'h1);
        wr(4'h4, 8'h00);
        cnt(c[0]);
        wait_mode <= 1'b1;
        wr(4'h4, 8'hFF);
        cnt(c[1]);
        chk("trim", 34'(c[0] > c[1] && c[1] > 0), 34'h1);
        chk("wait", 34'(int_osc_running), 34'h1);
        wait_mode <= 1'b0;
        $display("test freq done");
        wr(4'h8, 8'h01);
        pin(8'h00, 1'b1);
        chk("in", 34'(clock_input_pin_is_clock), 34'h0);
        pin(8'h80, 1'b1);
        pin(8'h40, 1'b0);
        rd(4'h8, 34'h0);
        pin(8'hC0, 1'b1);
        lvl <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("xtal", 34'(clock_output_pin_o), 34'h0);
        lvl <= 1'b0;
        wr(4'h8, 8'h00);
        pin(8'h00, 1'b0);
        $display("test pins done");
        monitor_bypass <= 1'b1;
        run <= 1'b1;
        wr(4'h0, 8'h42);
        repeat (60) @(posedge aclk);
        chk("bypass", 34'(int_osc_running), 34'h1);
        rd(4'h0, {26'h0, 8'h42});
        monitor_bypass <= 1'b0;
        wait_run(1'b0);
        chk("pinclk", 34'(clock_input_pin_is_clock), 34'h1);
        rd(4'h0, {26'h0, 8'h43});
        wr(4'h0, 8'h00);
        wait_run(1'b1);
        run <= 1'b0;
        rd(4'h0, 34'h0);
        $display("test engage done");
        stop_mode <= 1'b1;
        stop_osc_disable <= 1'b1;
        wait_run(1'b0);
        chk("stop", 34'(int_osc_running), 34'h0);
        stop_mode <= 1'b0;
        stop_osc_disable <= 1'b0;
        wait_run(1'b1);
        wr(4'h8, 8'h02);
        stop_mode <= 1'b1;
        stop_osc_disable <= 1'b1;
        repeat (40) @(posedge aclk);
        chk("keep", 34'(int_osc_running), 34'h1);
        $display("test stop done");
        finish_test();
    end
endmodule

// [design/oss_int_osc.sv]
`timescale 1ns/100ps
// Model of the trimmed internal oscillator as a tick generator
module oss_int_osc (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [1:0] freq_sel,
    input wire logic [7:0] trim,
    output logic tick
);
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] half_len;
    logic tick_d;

    // Period scales from the chosen frequency, trim offsets it
    function automatic logic [15:0] trimmed(input logic [1:0] f,
                                            input logic [7:0] t);
        logic [15:0] base;
        logic [25:0] prod;
        base = (f == 2'h1) ? 16'(oss_pkg::HALF_8M0) :
               (f == 2'h2) ? 16'(oss_pkg::HALF_12M8) :
               16'(oss_pkg::HALF_4M0);
        // Monotonic trim: 8'h80 gives base, each step about 1/512 more
        prod = 26'(base) * 26'(t);
        trimmed = 16'(base - (base >> 2) + 16'(prod >> oss_pkg::TRIM_SHIFT));
    endfunction

    assign half_len = trimmed(freq_sel, trim);

    // Count half-periods while running
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (run) begin
            if (cnt_q + 16'h0001 >= half_len) begin
                cnt_d = 16'h0000;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule

// [design/oss_pkg.sv]
// Functional notes
// - Block raises no interrupt requests at all
// - Keeps running and clocking in wait mode
// - Stop with stop_osc_disable runs only if keep bit set or in wait
// - Internal option with request bit clear frees input pin for I/O
// - Crystal option: output pin is inverted input
// - Internal/RC: output pin carries x4 when enabled
// - External clock option: output pin never clocks
// - Source select 00/01/10/11, reset internal
// - Internal freq 4.0/8.0/12.8 MHz, 11 reserved
// - Wait leaves logic unchanged, clocks continue
// - Crystal range selects amplifier, 11 reserved
// - Request bit enables input clock, reset clears
// - Monitor bypass mode ignores request bit
// - Engaged flag shows external clock in use
// - Trim step changes period about 0.2 percent
// - Trim applies to currently selected frequency
// - Two external rising edges, engage, stop internal
// - Clearing select and request returns to internal
// - x4 equals source, x2 is half of x4
// - External clock option forces output enable zero
package oss_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TRIM = 4'h4;
    // Control register field positions
    localparam int SRC_LSB = 6;
    localparam int FREQ_LSB = 4;
    localparam int RANGE_LSB = 2;
    localparam int REQ_BIT = 1;
    localparam int ENG_BIT = 0;
    // Extra control register: output pin enable and keep-in-stop
    localparam logic [3:0] ADDR_PINCFG = 4'h8;
    localparam int OUTEN_BIT = 0;
    localparam int STOPKEEP_BIT = 1;
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_RC = 2'h2;
    localparam logic [1:0] SRC_XTAL = 2'h3;
    localparam logic [1:0] FREQ_RSVD = 2'h3;
    localparam logic [1:0] RANGE_RSVD = 2'h3;
    localparam logic [7:0] TRIM_RESET = 8'h80;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int EDGES_TO_ENGAGE = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Internal clock half-period in 200 MHz cycles, untrimmed
    localparam int HALF_4M0 = 25;
    localparam int HALF_8M0 = 12;
    localparam int HALF_12M8 = 8;
    // One trim step is about 0.2 percent, in 1/512 period units
    localparam int TRIM_SHIFT = 9;
endpackage

// [design/oss_top.sv]
`timescale 1ns/100ps
// Clock source select, trim and pin control, AXI4-Lite registers
module oss_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_mode,
    input wire logic stop_osc_disable,
    input wire logic wait_mode,
    input wire logic monitor_bypass,
    input wire logic clock_input_pin,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe,
    output logic clock_input_pin_is_clock,
    output logic bus_clock_times4,
    output logic bus_clock_times2,
    output logic int_osc_running
);
    typedef enum logic [2:0] {
        OSS_INT = 3'b001,
        OSS_WAIT = 3'b010,
        OSS_EXT = 3'b100
    } oss_state_e;

    oss_state_e st_q, st_d;
    logic [1:0] src_q, src_d, freq_q, freq_d, range_q, range_d;
    logic req_q, req_d, outen_q, outen_d, keep_q, keep_d;
    logic [7:0] trim_q, trim_d;
    logic [1:0] edges_q, edges_d;
    logic engaged;
    logic in_s1_q, in_s2_q, in_s3_q;
    logic ext_rise;
    logic osc_halt, int_tick;
    logic x4_q, x4_d, x2_q, x2_d;
    logic out_o_d, out_oe_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [3:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic do_wr;
    logic [7:0] ctrl_rd;

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == oss_pkg::ADDR_CTRL) || (a == oss_pkg::ADDR_TRIM) ||
                 (a == oss_pkg::ADDR_PINCFG);
    endfunction

    // Interrupts: block has no request output at all
    assign engaged = (st_q == OSS_EXT);
    // Wait mode never halts the oscillator: clocks keep running
    // Stop with stop_osc_disable shuts the oscillator unless keep bit set or in wait
    assign osc_halt = stop_mode && stop_osc_disable && !keep_q
                      && !wait_mode;
    assign ext_rise = in_s2_q && !in_s3_q; // Reads synced copies only

    oss_int_osc u_osc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(!osc_halt && (st_q != OSS_EXT)),
        .freq_sel(freq_q),
        .trim(trim_q),
        .tick(int_tick)
    );

    // Pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
            in_s3_q <= 1'b0;
        end else begin
            in_s1_q <= clock_input_pin;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end

    // Switch-over sequencer
    always_comb begin
        st_d = st_q;
        edges_d = edges_q;
        unique case (st_q)
            OSS_INT: begin
                edges_d = 2'h0;
                if (req_q && !monitor_bypass) begin
                    st_d = OSS_WAIT;
                end
            end
            OSS_WAIT: begin
                if (!req_q || monitor_bypass) begin
                    st_d = OSS_INT;
                end else if (ext_rise) begin
                    edges_d = edges_q + 2'h1;
                    if (edges_q == 2'(oss_pkg::EDGES_TO_ENGAGE - 1)) begin
                        st_d = OSS_EXT;
                    end
                end
            end
            OSS_EXT: begin
                if (!req_q && src_q == oss_pkg::SRC_INT) begin
                    st_d = OSS_INT;
                end
            end
        endcase
    end

    // Bus clocks: x4 toggles on each source half-period, x2 halves it
    always_comb begin
        // Engaged: x4 follows the synced pin, no divider in the path
        x4_d = x4_q;
        x2_d = x2_q;
        if (engaged) begin
            x4_d = in_s2_q;
        end else if (int_tick) begin
            x4_d = !x4_q;
        end
        if (x4_d && !x4_q) begin
            x2_d = !x2_q;
        end
        if (osc_halt) begin
            x4_d = x4_q;
            x2_d = x2_q;
        end
    end

    // Pin functions per source option
    always_comb begin
        out_o_d = 1'b0;
        out_oe_d = 1'b0;
        unique case (src_q)
            oss_pkg::SRC_XTAL: begin
                out_o_d = !in_s2_q;
                out_oe_d = 1'b1;
            end
            oss_pkg::SRC_EXT: begin
                out_oe_d = 1'b0;
            end
            default: begin
                out_o_d = x4_d;
                out_oe_d = outen_q;
            end
        endcase
    end

    // Register update and AXI write path
    assign do_wr = aw_q && w_q && !bv_q;
    always_comb begin
        src_d = src_q;
        freq_d = freq_q;
        range_d = range_q;
        req_d = req_q;
        trim_d = trim_q;
        outen_d = outen_q;
        keep_d = keep_q;
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        // A new request waits until the pending answer is taken
        if (s_axi_awvalid && !aw_q && !bv_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q && !bv_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (do_wr) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = mapped(awa_q) ? oss_pkg::RESP_OKAY : oss_pkg::RESP_SLVERR;
            if (awa_q == oss_pkg::ADDR_CTRL) begin
                src_d = wd_q[oss_pkg::SRC_LSB +: 2];
                if (wd_q[oss_pkg::FREQ_LSB +: 2] != oss_pkg::FREQ_RSVD) begin
                    freq_d = wd_q[oss_pkg::FREQ_LSB +: 2];
                end
                if (wd_q[oss_pkg::RANGE_LSB +: 2] != oss_pkg::RANGE_RSVD) begin
                    range_d = wd_q[oss_pkg::RANGE_LSB +: 2];
                end
                req_d = wd_q[oss_pkg::REQ_BIT];
            end
            if (awa_q == oss_pkg::ADDR_TRIM) begin
                trim_d = wd_q[7:0];
            end
            if (awa_q == oss_pkg::ADDR_PINCFG) begin
                outen_d = wd_q[oss_pkg::OUTEN_BIT];
                keep_d = wd_q[oss_pkg::STOPKEEP_BIT];
            end
        end
        if (src_d == oss_pkg::SRC_EXT) begin
            outen_d = 1'b0;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
    end

    // AXI read path
    assign ctrl_rd = {src_q, freq_q, range_q, req_q, engaged};
    always_comb begin
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = oss_pkg::RESP_OKAY;
            rd_d = 32'h0000_0000;
            unique case (s_axi_araddr)
                oss_pkg::ADDR_CTRL: rd_d = {24'h00_0000, ctrl_rd};
                oss_pkg::ADDR_TRIM: rd_d = {24'h00_0000, trim_q};
                oss_pkg::ADDR_PINCFG: rd_d = {30'h0000_0000, keep_q, outen_q};
                default: rr_d = oss_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= OSS_INT;
            edges_q <= 2'h0;
            src_q <= oss_pkg::SRC_INT;
            freq_q <= 2'h0;
            range_q <= 2'h0;
            req_q <= 1'b0;
            trim_q <= oss_pkg::TRIM_RESET;
            outen_q <= 1'b0;
            keep_q <= 1'b0;
            x4_q <= 1'b0;
            x2_q <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 4'h0;
            wd_q <= 32'h0000_0000;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rr_q <= 2'h0;
            clock_output_pin_o <= 1'b0;
            clock_output_pin_oe <= 1'b0;
            clock_input_pin_is_clock <= 1'b0;
            int_osc_running <= 1'b0;
        end else begin
            st_q <= st_d;
            edges_q <= edges_d;
            src_q <= src_d;
            freq_q <= freq_d;
            range_q <= range_d;
            req_q <= req_d;
            trim_q <= trim_d;
            outen_q <= outen_d;
            keep_q <= keep_d;
            x4_q <= x4_d;
            x2_q <= x2_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            clock_output_pin_o <= out_o_d;
            clock_output_pin_oe <= out_oe_d;
            // Input pin released to I/O under internal option with request bit clear
            clock_input_pin_is_clock <= (src_q != oss_pkg::SRC_INT) || req_q;
            int_osc_running <= !osc_halt && (st_q != OSS_EXT);
        end
    end

    // Readies stay low while a write answer stands: one write at a time
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !w_q && !bv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign bus_clock_times4 = x4_q;
    assign bus_clock_times2 = x2_q;
endmodule
